// file: core/gpc_defs.svh
// Offsets, field positions, reset values and fixed codes of the pin and threshold bank
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define GPC_OFS_OUT2        6'h00
`define GPC_OFS_OUT1        6'h01
`define GPC_OFS_OUT0        6'h02
`define GPC_OFS_THR         6'h03
`define GPC_OFS_TEST_A      6'h10
`define GPC_OFS_TEST_B      6'h11

// ****************************************
// Field positions
// ****************************************
`define GPC_BIT_HIGH        7
`define GPC_BIT_INV         6
`define GPC_SEL_MSB         5
`define GPC_BIT_KEEP        6
`define GPC_ATT_MSB         5
`define GPC_ATT_LSB         4
`define GPC_THR_MSB         3

// ****************************************
// Reset values
// ****************************************
`define GPC_RST_OUT2        8'h29
`define GPC_RST_OUT1        8'h2E
`define GPC_RST_OUT0        8'h3F
`define GPC_RST_THR         8'h07
`define GPC_RST_TEST_A      8'h31
`define GPC_RST_TEST_B      8'h88

// ****************************************
// Fixed codes
// ****************************************
`define GPC_SEL_HIZ         6'h2E
`define GPC_WAKE_A_CLR      8'h31
`define GPC_WAKE_B_CLR      8'h88
`define GPC_WAKE_A_SET      8'h35
`define GPC_WAKE_B_SET      8'h81
`define GPC_TX_SPAN         7'h41
`define GPC_RX_STEP         7'h04

`endif

// file: core/gpc_pkg.sv
// Types shared by the pin and threshold bank
package gpc_pkg;
    typedef logic [7:0] gpc_byte_t;
    typedef logic [6:0] gpc_count_t;

    // Sleep tracking, one-hot
    typedef enum logic [2:0] {
        GPC_ST_AWAKE = 3'b001,
        GPC_ST_SLEEP = 3'b010,
        GPC_ST_WAKE  = 3'b100
    } gpc_wake_e;
endpackage

// file: core/gpc_thr_cmp.sv
// Registered comparison of a byte count against a fill limit
`timescale 1ns/1ps
`include "gpc_defs.svh"

module gpc_thr_cmp (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    // Count and limit
    input  wire gpc_pkg::gpc_count_t count_i,
    input  wire gpc_pkg::gpc_count_t limit_i,
    // Result
    output logic                    reached_o
);

    // Equal counts as reached, so a full limit still flags
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reached_o <= 1'b0;
        end else begin
            reached_o <= (count_i >= limit_i);
        end
    end

endmodule

// file: core/gpc_cfg_bank.sv
// Pin configuration and fifo threshold register bank with its output logic
`timescale 1ns/1ps
`include "gpc_defs.svh"

module gpc_cfg_bank (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    // Register port
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [5:0]           reg_addr_i,
    input  wire gpc_pkg::gpc_byte_t   reg_wdata_i,
    output gpc_pkg::gpc_byte_t        reg_rdata_o,
    // Power state
    input  wire logic                 sleep_i,
    // Internal signal sources, indexed by select code
    input  wire logic [63:0]          gp_sig_i,
    // Fifo fill levels
    input  wire gpc_pkg::gpc_count_t  tx_bytes_i,
    input  wire gpc_pkg::gpc_count_t  rx_bytes_i,
    // General purpose pins
    output logic [2:0]                gp_pin_o,
    output logic [2:0]                gp_pin_oe_n_o,
    output logic                      gp_pin_drive_strength_o,
    // Analog controls
    output logic                      temp_sensor_en_o,
    output logic [1:0]                close_in_atten_o,
    output gpc_pkg::gpc_byte_t        analog_test_a_o,
    output gpc_pkg::gpc_byte_t        analog_test_b_o,
    // Fifo threshold flags
    output logic                      tx_thr_reached_o,
    output logic                      rx_thr_reached_o
);

    // ****************************************
    // Decode helpers
    // ****************************************

    // Receive limit for a threshold setting: four bytes per step
    function automatic gpc_pkg::gpc_count_t rx_limit(input logic [3:0] setting);
        gpc_pkg::gpc_count_t step_base;
        step_base = {1'b0, setting, 2'b00};
        rx_limit  = step_base + `GPC_RX_STEP;
    endfunction

    // Reset value of each stored register by index
    function automatic gpc_pkg::gpc_byte_t reset_value(input int unsigned idx);
        gpc_pkg::gpc_byte_t val;
        val = 8'h00;
        case (idx)
            0: val = `GPC_RST_OUT2;
            1: val = `GPC_RST_OUT1;
            2: val = `GPC_RST_OUT0;
            default: val = `GPC_RST_THR;
        endcase
        reset_value = val;
    endfunction

    // ****************************************
    // Register storage
    // ****************************************

    // Index 0..2 hold the pin registers, 3 the threshold register
    gpc_pkg::gpc_byte_t   cfg [4];
    gpc_pkg::gpc_wake_e   wake_state;
    gpc_pkg::gpc_wake_e   next_wake_state;
    gpc_pkg::gpc_count_t  tx_limit;
    gpc_pkg::gpc_count_t  rx_limit_val;
    logic [1:0]           thr_hit;
    logic                 addr_stored;
    logic [1:0]           addr_idx;

    // Address falls into the stored block when it is one of the four offsets
    assign addr_stored = (reg_addr_i <= `GPC_OFS_THR);
    assign addr_idx    = reg_addr_i[1:0];

    // One process per stored register; values survive sleep untouched
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cfg
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    cfg[gi] <= reset_value(gi);
                end else if (reg_wr_i && addr_stored && (addr_idx == gi)) begin
                    if (gi == 0) begin
                        // Top bit of pin 2 is not implemented
                        cfg[gi] <= {1'b0, reg_wdata_i[6:0]};
                    end else begin
                        // Reserved threshold bit is kept as written
                        cfg[gi] <= reg_wdata_i;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Read port
    // ****************************************

    // Test registers always read back their reset values; the wake-up
    // loads only reach the analog side, never this read path
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (addr_stored) begin
                reg_rdata_o <= cfg[addr_idx];
            end else if (reg_addr_i == `GPC_OFS_TEST_A) begin
                reg_rdata_o <= `GPC_RST_TEST_A;
            end else if (reg_addr_i == `GPC_OFS_TEST_B) begin
                reg_rdata_o <= `GPC_RST_TEST_B;
            end else begin
                reg_rdata_o <= 8'h00; // Unmapped reads as zero
            end
        end
    end

    // ****************************************
    // Sleep tracking
    // ****************************************

    // Next state: the wake state lasts exactly one cycle
    always_comb begin
        next_wake_state = wake_state;
        unique case (wake_state)
            gpc_pkg::GPC_ST_AWAKE: begin
                if (sleep_i) begin
                    next_wake_state = gpc_pkg::GPC_ST_SLEEP;
                end
            end
            gpc_pkg::GPC_ST_SLEEP: begin
                if (!sleep_i) begin
                    next_wake_state = gpc_pkg::GPC_ST_WAKE;
                end
            end
            gpc_pkg::GPC_ST_WAKE: begin
                next_wake_state = sleep_i ? gpc_pkg::GPC_ST_SLEEP
                                          : gpc_pkg::GPC_ST_AWAKE;
            end
            default: begin
                next_wake_state = gpc_pkg::GPC_ST_AWAKE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wake_state <= gpc_pkg::GPC_ST_AWAKE;
        end else begin
            wake_state <= next_wake_state;
        end
    end

    // ****************************************
    // Analog test settings
    // ****************************************

    // Loaded on the cycle the device leaves sleep; the keep bit picks the set
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            analog_test_a_o <= `GPC_RST_TEST_A;
            analog_test_b_o <= `GPC_RST_TEST_B;
        end else if (next_wake_state == gpc_pkg::GPC_ST_WAKE) begin
            if (cfg[3][`GPC_BIT_KEEP]) begin
                analog_test_a_o <= `GPC_WAKE_A_SET;
                analog_test_b_o <= `GPC_WAKE_B_SET;
            end else begin
                analog_test_a_o <= `GPC_WAKE_A_CLR;
                analog_test_b_o <= `GPC_WAKE_B_CLR;
            end
        end
    end

    // ****************************************
    // Analog controls
    // ****************************************

    // Registered copies so every control leaves through a flip-flop
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            temp_sensor_en_o        <= 1'b0;
            close_in_atten_o        <= 2'b00;
            gp_pin_drive_strength_o <= 1'b0;
        end else begin
            // The host clears the rest of pin-0 config when the sensor is used
            temp_sensor_en_o        <= cfg[2][`GPC_BIT_HIGH];
            close_in_atten_o        <= cfg[3][`GPC_ATT_MSB:`GPC_ATT_LSB];
            gp_pin_drive_strength_o <= cfg[1][`GPC_BIT_HIGH];
        end
    end

    // ****************************************
    // General purpose pins
    // ****************************************

    // Pin k is held at index 2-k; one registered mux per pin.
    // The divided crystal clock must be supplied on source 63; the host
    // should deselect it early since it disturbs reception.
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            logic [5:0] pin_sel;
            assign pin_sel = cfg[2 - gi][`GPC_SEL_MSB:0];

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    gp_pin_o[gi]      <= 1'b0;
                    gp_pin_oe_n_o[gi] <= 1'b1;
                end else if (pin_sel == `GPC_SEL_HIZ) begin
                    // Undriven code releases the pin
                    gp_pin_o[gi]      <= 1'b0;
                    gp_pin_oe_n_o[gi] <= 1'b1;
                end else begin
                    gp_pin_o[gi]      <= gp_sig_i[pin_sel]
                                         ^ cfg[2 - gi][`GPC_BIT_INV];
                    gp_pin_oe_n_o[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Fifo thresholds
    // ****************************************

    // One setting serves both fifos; transmit mirrors receive
    assign rx_limit_val = rx_limit(cfg[3][`GPC_THR_MSB:0]);
    assign tx_limit     = `GPC_TX_SPAN - rx_limit(cfg[3][`GPC_THR_MSB:0]);

    // Comparators register their result, so thr_hit lags the count by one cycle
    gpc_thr_cmp u_tx_cmp (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .count_i   (tx_bytes_i),
        .limit_i   (tx_limit),
        .reached_o (thr_hit[0])
    );

    gpc_thr_cmp u_rx_cmp (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .count_i   (rx_bytes_i),
        .limit_i   (rx_limit_val),
        .reached_o (thr_hit[1])
    );

    // Flags leave through a second stage so both track together
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_thr_reached_o <= 1'b0;
            rx_thr_reached_o <= 1'b0;
        end else begin
            tx_thr_reached_o <= thr_hit[0];
            rx_thr_reached_o <= thr_hit[1];
        end
    end

endmodule

// file: bench/gpc_cfg_bank_sva.sv
// Assertion checker for the pin and threshold register bank
`timescale 1ns/1ps
module gpc_cfg_bank_sva (
    // Clock, reset and inputs
    input wire logic                clock_i,
    input wire logic                rst_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [5:0]          reg_addr_i,
    input wire gpc_pkg::gpc_byte_t  reg_wdata_i,
    input wire logic                sleep_i,
    input wire logic [63:0]         gp_sig_i,
    input wire gpc_pkg::gpc_count_t tx_bytes_i,
    input wire gpc_pkg::gpc_count_t rx_bytes_i,
    // Outputs under watch
    input wire gpc_pkg::gpc_byte_t  reg_rdata_o,
    input wire logic [2:0]          gp_pin_o,
    input wire logic [2:0]          gp_pin_oe_n_o,
    input wire logic                gp_pin_drive_strength_o,
    input wire logic                temp_sensor_en_o,
    input wire logic [1:0]          close_in_atten_o,
    input wire gpc_pkg::gpc_byte_t  analog_test_a_o,
    input wire gpc_pkg::gpc_byte_t  analog_test_b_o,
    input wire logic                tx_thr_reached_o,
    input wire logic                rx_thr_reached_o
);
    logic [1:0]          age;
    logic                drv, tmp, exp0, rx_hit, tx_hit;
    logic [1:0]          att;
    gpc_pkg::gpc_byte_t  sh0, thr;
    gpc_pkg::gpc_count_t rx_lim;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Shadow registers; age hides the output pipeline filling after reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            age <= 2'h0;
            drv <= 1'b0;
            sh0 <= 8'h3F;
            thr <= 8'h07;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            if (reg_wr_i && reg_addr_i == 6'h01) drv <= reg_wdata_i[7];
            if (reg_wr_i && reg_addr_i == 6'h02) sh0 <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 6'h03) thr <= reg_wdata_i;
        end
    end
    // Expected pin-0 level and fill limits from the shadows
    assign tmp = sh0[7];
    assign att = thr[5:4];
    assign exp0 = gp_sig_i[sh0[5:0]] ^ sh0[6];
    assign rx_lim = 7'({thr[3:0], 2'b00}) + 7'h04;
    assign rx_hit = rx_bytes_i >= rx_lim;
    assign tx_hit = tx_bytes_i >= 7'h41 - rx_lim;
    // Two quiet cycles first, so the sleep state is surely awake
    sequence s_wake(bit k);
        !sleep_i [*2] ##1 sleep_i ##1 (!sleep_i && thr[6] == k);
    endsequence
    a_drive_follow: assert property (age == 2'h3 |-> gp_pin_drive_strength_o == $past(drv))
        else $error("drive strength differs from pin-1 bit 7");
    a_temp_follow: assert property (age == 2'h3 |-> temp_sensor_en_o == $past(tmp))
        else $error("temperature enable differs from pin-0 bit 7");
    a_atten_follow: assert property (age == 2'h3 |-> close_in_atten_o == $past(att))
        else $error("attenuation differs from threshold bits 5:4");
    a_pin1_release: assert property (reg_wr_i && reg_addr_i == 6'h01 && reg_wdata_i[5:0] == 6'h2E
        |-> ##2 gp_pin_oe_n_o[1] && !gp_pin_o[1]) else $error("pin 1 not released");
    a_pin0_value: assert property (age == 2'h3 && sh0[5:0] != 6'h2E
        |=> gp_pin_o[0] == $past(exp0) && !gp_pin_oe_n_o[0]) else $error("pin 0 level wrong");
    a_rx_flag: assert property (age == 2'h3 |-> rx_thr_reached_o == $past(rx_hit, 2))
        else $error("receive threshold flag wrong");
    a_tx_flag: assert property (age == 2'h3 |-> tx_thr_reached_o == $past(tx_hit, 2))
        else $error("transmit threshold flag wrong");
    a_wake_keep_set: assert property (s_wake(1'b1)
        |=> analog_test_a_o == 8'h35 && analog_test_b_o == 8'h81) else $error("wake values wrong");
    a_wake_keep_clr: assert property (s_wake(1'b0)
        |=> analog_test_a_o == 8'h31 && analog_test_b_o == 8'h88) else $error("wake values wrong");
    a_test_read: assert property (reg_rd_i && reg_addr_i == 6'h10 |=> reg_rdata_o == 8'h31)
        else $error("test register read not reset value");
    a_unused_bit: assert property (reg_rd_i && reg_addr_i == 6'h00 |=> !reg_rdata_o[7])
        else $error("pin-2 bit 7 reads one");
endmodule

bind gpc_cfg_bank gpc_cfg_bank_sva u_sva (
    .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .sleep_i(sleep_i), .gp_sig_i(gp_sig_i),
    .tx_bytes_i(tx_bytes_i), .rx_bytes_i(rx_bytes_i), .reg_rdata_o(reg_rdata_o),
    .gp_pin_o(gp_pin_o), .gp_pin_oe_n_o(gp_pin_oe_n_o),
    .gp_pin_drive_strength_o(gp_pin_drive_strength_o), .temp_sensor_en_o(temp_sensor_en_o),
    .close_in_atten_o(close_in_atten_o), .analog_test_a_o(analog_test_a_o),
    .analog_test_b_o(analog_test_b_o), .tx_thr_reached_o(tx_thr_reached_o),
    .rx_thr_reached_o(rx_thr_reached_o)
);

// file: bench/gpc_cfg_bank_test.sv
// Self-checking testbench for the pin and threshold register bank
`timescale 1ns/1ps
module gpc_cfg_bank_test;
    logic                clock_i, rst_i, reg_wr_i, reg_rd_i, sleep_i, drv, tmp;
    logic [5:0]          reg_addr_i;
    logic [63:0]         gp_sig_i;
    gpc_pkg::gpc_byte_t  reg_wdata_i, reg_rdata_o, analog_test_a_o, analog_test_b_o;
    gpc_pkg::gpc_count_t tx_bytes_i, rx_bytes_i, lim;
    logic [2:0]          gp_pin_o, gp_pin_oe_n_o;
    logic [1:0]          close_in_atten_o;
    logic                tx_thr_reached_o, rx_thr_reached_o;
    int                  n_mismatch, total_checks;

    gpc_cfg_bank u_gpc_cfg_bank (
        .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sleep_i(sleep_i), .gp_sig_i(gp_sig_i), .tx_bytes_i(tx_bytes_i), .rx_bytes_i(rx_bytes_i),
        .gp_pin_o(gp_pin_o), .gp_pin_oe_n_o(gp_pin_oe_n_o), .gp_pin_drive_strength_o(drv),
        .temp_sensor_en_o(tmp), .close_in_atten_o(close_in_atten_o),
        .analog_test_a_o(analog_test_a_o), .analog_test_b_o(analog_test_b_o),
        .tx_thr_reached_o(tx_thr_reached_o), .rx_thr_reached_o(rx_thr_reached_o)
    );

    // ****************************************
    // Clock, tasks and verdict
    // ****************************************
    // 40 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Inputs always move 1 ns after an edge, clear of the sampling point
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // An idle cycle closes each access, so a strobe never toggles twice in one step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        tick(1);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp);
        tick(1);
    endtask

    task automatic give_verdict;
        $display("Checks made: %0d, mismatches: %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #100000;
        n_mismatch++;
        give_verdict;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, sleep_i} = 4'h8;
        reg_addr_i = 6'h00;
        reg_wdata_i = 8'h00;
        gp_sig_i = 64'h8000_0200_0000_0000;
        tx_bytes_i = 7'h00;
        rx_bytes_i = 7'h00;
        n_mismatch = 0;
        total_checks = 0;
        tick(5);
        rst_i = 1'b0;
        tick(1);
        chk({5'h00, gp_pin_o}, 8'h05);
        chk({5'h00, gp_pin_oe_n_o}, 8'h02);
        rd(6'h00, 8'h29);
        rd(6'h01, 8'h2E);
        rd(6'h02, 8'h3F);
        rd(6'h03, 8'h07);
        wr(6'h00, 8'hFF);
        rd(6'h00, 8'h7F);
        chk({5'h00, gp_pin_o}, 8'h01);
        // Pin-0 clock output switched off during set-up (pin 2 still selects source 63), sensor on
        wr(6'h02, 8'h80);
        wr(6'h01, 8'hC0);
        chk({4'h0, tmp, gp_pin_o}, 8'h0A);
        chk({4'h0, drv, gp_pin_oe_n_o}, 8'h08);
        wr(6'h01, 8'h2E);
        chk({4'h0, drv, gp_pin_oe_n_o}, 8'h02);
        // Every threshold setting, counts at and one below each limit
        for (int n = 0; n < 16; n++) begin
            wr(6'h03, {2'b00, 2'(n), 4'(n)});
            chk({6'h00, close_in_atten_o}, 8'(n % 4));
            lim = 7'(4 * (n + 1));
            for (int d = 0; d < 2; d++) begin
                rx_bytes_i = lim - 7'(d);
                tx_bytes_i = 7'h41 - lim - 7'(d);
                tick(2);
                chk({6'h00, rx_thr_reached_o, tx_thr_reached_o}, (d == 0) ? 8'h03 : 8'h00);
            end
        end
        // Sleep and wake with the keep bit clear, then set
        for (int k = 0; k < 2; k++) begin
            wr(6'h03, {1'b0, 1'(k), 6'h07});
            // One sleeping edge, so the checker's wake sequence sees this visit
            sleep_i = 1'b1;
            tick(1);
            sleep_i = 1'b0;
            tick(2);
            chk(analog_test_a_o, (k == 1) ? 8'h35 : 8'h31);
            chk(analog_test_b_o, (k == 1) ? 8'h81 : 8'h88);
            rd(6'h10, 8'h31);
            rd(6'h11, 8'h88);
        end
        rd(6'h03, 8'h47);
        wr(6'h3F, 8'h55);
        rd(6'h3F, 8'h00);
        // Reset in mid-run restores the defaults
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        tick(1);
        rd(6'h02, 8'h3F);
        chk({5'h00, gp_pin_oe_n_o}, 8'h02);
        give_verdict;
    end
endmodule
